// >>> cbt_pkg.sv
/*
 cbt_pkg: shared constants and types for the CAN channel bit timing and
 fault state logic.
 assumes: a single 25 MHz controller clock; all users reference names
 as cbt_pkg::name without import.
*/
package cbt_pkg;

   // controller clock and the transceiver bit rate window
   localparam int CLK_HZ = 25_000_000;
   localparam int RATE_MIN_BPS = 5_000;
   localparam int RATE_MAX_BPS = 1_000_000;
   // bit rate = clk / (prescaler * quanta); limits become product bounds
   localparam int PROD_MIN_I = (CLK_HZ + RATE_MAX_BPS - 1) / RATE_MAX_BPS;
   localparam int PROD_MAX_I = CLK_HZ / RATE_MIN_BPS;
   localparam int PROD_W = 14;
   localparam logic [PROD_W-1:0] PROD_MIN = PROD_W'(PROD_MIN_I);
   localparam logic [PROD_W-1:0] PROD_MAX = PROD_W'(PROD_MAX_I);

   // field widths
   localparam int BRP_W = 9;
   localparam int SEG_W = 4;
   localparam int SJW_W = 3;
   localparam int TQ_W = 5;
   localparam int ERR_W = 9;

   // accepted field ranges
   localparam logic [BRP_W-1:0] BRP_MIN = 9'h001;
   localparam logic [BRP_W-1:0] BRP_MAX = 9'h100;
   localparam logic [SEG_W-1:0] PROP_MIN = 4'h1;
   localparam logic [SEG_W-1:0] PROP_MAX = 4'h8;
   localparam logic [SEG_W-1:0] PH1_MIN = 4'h1;
   localparam logic [SEG_W-1:0] PH1_MAX = 4'h8;
   localparam logic [SEG_W-1:0] PH2_MIN = 4'h2;
   localparam logic [SEG_W-1:0] PH2_MAX = 4'h8;
   localparam logic [SJW_W-1:0] SJW_MIN = 3'h1;
   localparam logic [SJW_W-1:0] SJW_MAX = 3'h4;
   localparam logic [TQ_W-1:0] TSEG1_MIN = 5'h04;
   localparam logic [TQ_W-1:0] SYNC_TQ = 5'h01;

   // applied timing after reset: 5 * (1 + 6 + 3) quanta = 500 kbit/s
   localparam logic [BRP_W-1:0] BRP_RST = 9'h005;
   localparam logic [SEG_W-1:0] PROP_RST = 4'h3;
   localparam logic [SEG_W-1:0] PH1_RST = 4'h3;
   localparam logic [SEG_W-1:0] PH2_RST = 4'h3;
   localparam logic [SJW_W-1:0] SJW_RST = 3'h1;

   // error counter thresholds and steps
   localparam logic [ERR_W-1:0] ERR_WARN = 9'h060;
   localparam logic [ERR_W-1:0] ERR_PASSIVE = 9'h080;
   localparam logic [ERR_W-1:0] ERR_OFF_ABOVE = 9'h0ff;
   localparam logic [ERR_W-1:0] ERR_UP_STEP = 9'h008;
   localparam logic [ERR_W-1:0] ERR_DN_STEP = 9'h001;
   localparam logic [ERR_W-1:0] ERR_SAT = 9'h1ff;
   localparam logic [ERR_W-1:0] ERR_ZERO = 9'h000;

   // reported channel state, one-hot
   typedef enum logic [4:0] {
      CH_INACTIVE = 5'h01,
      CH_ACTIVE = 5'h02,
      CH_WARNING = 5'h04,
      CH_PASSIVE = 5'h08,
      CH_BUSOFF = 5'h10
   } cbt_chan_e;

   // bit segment being timed, one-hot
   typedef enum logic [2:0] {
      SG_SYNC = 3'h1,
      SG_TSEG1 = 3'h2,
      SG_TSEG2 = 3'h4
   } cbt_seg_e;

endpackage

// >>> cbt_timing_if.sv
/*
 cbt_timing_if: one set of bit timing fields passed between the channel
 and its checker or bit timer.
 assumes: the channel drives every field; readers only sample them.
*/
`timescale 1ns/10ps
interface cbt_timing_if;
   logic [cbt_pkg::BRP_W-1:0] brp;
   logic [cbt_pkg::SEG_W-1:0] prop;
   logic [cbt_pkg::SEG_W-1:0] ph1;
   logic [cbt_pkg::SEG_W-1:0] ph2;
   logic [cbt_pkg::SJW_W-1:0] sjw;

   modport src (output brp, output prop, output ph1, output ph2, output sjw);
   modport snk (input brp, input prop, input ph1, input ph2, input sjw);
endinterface

// >>> cbt_timing_check.sv
/*
 cbt_timing_check: combinational range and bit rate check of a candidate
 timing set.
 assumes: fields arrive on the same clock domain; holds no state.
*/
`timescale 1ns/10ps
module cbt_timing_check (
   cbt_timing_if.snk cfg,
   output logic cfg_ok
);

   logic [cbt_pkg::TQ_W-1:0] tseg1;
   logic [cbt_pkg::TQ_W-1:0] nq;
   logic [cbt_pkg::PROD_W-1:0] prod;

   // range test shared by the three segment fields
   function automatic logic seg_in(input logic [cbt_pkg::SEG_W-1:0] v,
                                   input logic [cbt_pkg::SEG_W-1:0] lo,
                                   input logic [cbt_pkg::SEG_W-1:0] hi);
      seg_in = (v >= lo) && (v <= hi);
   endfunction

   // total quanta and divide product; bit rate limits are product bounds
   // so no divider is needed
   always_comb begin
      tseg1 = cbt_pkg::TQ_W'(cfg.prop) + cbt_pkg::TQ_W'(cfg.ph1);
      nq = cbt_pkg::SYNC_TQ + tseg1 + cbt_pkg::TQ_W'(cfg.ph2);
      prod = cbt_pkg::PROD_W'(cfg.brp) * cbt_pkg::PROD_W'(nq);
      cfg_ok = (cfg.brp >= cbt_pkg::BRP_MIN)
         && (cfg.brp <= cbt_pkg::BRP_MAX)
         && seg_in(cfg.ph1, cbt_pkg::PH1_MIN, cbt_pkg::PH1_MAX)
         && seg_in(cfg.ph2, cbt_pkg::PH2_MIN, cbt_pkg::PH2_MAX)
         && seg_in(cfg.prop, cbt_pkg::PROP_MIN, cbt_pkg::PROP_MAX)
         && (tseg1 >= cbt_pkg::TSEG1_MIN)
         && (cfg.sjw >= cbt_pkg::SJW_MIN)
         && (cfg.sjw <= cbt_pkg::SJW_MAX)
         && (prod >= cbt_pkg::PROD_MIN)
         && (prod <= cbt_pkg::PROD_MAX);
   end

endmodule

// >>> cbt_bit_timer.sv
/*
 cbt_bit_timer: quantum prescaler and segment sequencer of one bit,
 with jump-width limited resynchronisation.
 assumes: timing fields were validated before they reach it; rx_edge is
 a one-cycle pulse from synchronised receive data.
*/
`timescale 1ns/10ps
module cbt_bit_timer (
   input wire logic clk,
   input wire logic rst,
   cbt_timing_if.snk cfg,
   input wire logic run,
   input wire logic rx_edge,
   output logic sample_pulse,
   output logic bit_start
);

   typedef struct packed {
      cbt_pkg::cbt_seg_e seg;
      logic [cbt_pkg::BRP_W-1:0] psc;
      logic [cbt_pkg::TQ_W-1:0] cnt;
      logic [cbt_pkg::TQ_W-1:0] lim1;
      logic [cbt_pkg::TQ_W-1:0] lim2;
      logic resynced;
      logic sample;
      logic start;
   } cbt_tmr_s;

   localparam cbt_tmr_s TMR_RST = '{seg: cbt_pkg::SG_SYNC,
      psc: '0, cnt: '0, lim1: '0, lim2: '0, resynced: 1'b0,
      sample: 1'b0, start: 1'b0};

   cbt_tmr_s r_reg;
   cbt_tmr_s r_next;
   logic tick;
   logic [cbt_pkg::TQ_W-1:0] sjw5;

   assign sample_pulse = r_reg.sample;
   assign bit_start = r_reg.start;

   // next state: prescaler, resync adjustment, then segment stepping
   always_comb begin
      r_next = r_reg;
      r_next.sample = 1'b0;
      r_next.start = 1'b0;
      sjw5 = cbt_pkg::TQ_W'(cfg.sjw);
      // compare as at-or-above: a shorter prescale applied mid-quantum
      // must not wait for the counter to wrap
      tick = (r_reg.psc >= (cfg.brp - cbt_pkg::BRP_MIN));
      if (!run) begin
         r_next = TMR_RST;
      end else begin
         r_next.psc = tick ? '0 : r_reg.psc + cbt_pkg::BRP_MIN;
         // one resync per bit; an edge in sync is on time
         if (rx_edge && !r_reg.resynced) begin
            unique case (r_reg.seg)
               cbt_pkg::SG_SYNC: begin
               end
               cbt_pkg::SG_TSEG1: begin
                  r_next.lim1 = r_reg.lim1 + sjw5;
                  r_next.resynced = 1'b1;
               end
               cbt_pkg::SG_TSEG2: begin
                  // shorten, but never behind the quantum already counted
                  if (r_reg.lim2 > (r_reg.cnt + sjw5)) begin
                     r_next.lim2 = r_reg.lim2 - sjw5;
                  end else begin
                     r_next.lim2 = r_reg.cnt + cbt_pkg::SYNC_TQ;
                  end
                  r_next.resynced = 1'b1;
               end
            endcase
         end
         if (tick) begin
            unique case (r_reg.seg)
               cbt_pkg::SG_SYNC: begin
                  // sync segment always lasts exactly one quantum
                  r_next.seg = cbt_pkg::SG_TSEG1;
                  r_next.cnt = '0;
                  r_next.lim1 = cbt_pkg::TQ_W'(cfg.prop)
                     + cbt_pkg::TQ_W'(cfg.ph1);
                  r_next.lim2 = cbt_pkg::TQ_W'(cfg.ph2);
                  r_next.resynced = 1'b0;
               end
               cbt_pkg::SG_TSEG1: begin
                  if ((r_next.cnt + cbt_pkg::SYNC_TQ) >= r_next.lim1) begin
                     r_next.seg = cbt_pkg::SG_TSEG2;
                     r_next.cnt = '0;
                     r_next.sample = 1'b1;
                  end else begin
                     r_next.cnt = r_reg.cnt + cbt_pkg::SYNC_TQ;
                  end
               end
               cbt_pkg::SG_TSEG2: begin
                  if ((r_next.cnt + cbt_pkg::SYNC_TQ) >= r_next.lim2) begin
                     r_next.seg = cbt_pkg::SG_SYNC;
                     r_next.cnt = '0;
                     r_next.start = 1'b1;
                  end else begin
                     r_next.cnt = r_reg.cnt + cbt_pkg::SYNC_TQ;
                  end
               end
            endcase
         end
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         r_reg <= TMR_RST;
      end else begin
         r_reg <= r_next;
      end
   end

endmodule

// >>> cbt_channel.sv
/*
 cbt_channel: one CAN channel's timing configuration, fault state and
 bus participation gate.
 assumes: error events and transmit requests come from protocol logic on
 clk; rx_pin comes straight from the transceiver and is asynchronous.
*/
`timescale 1ns/10ps
module cbt_channel (
   input wire logic clk,
   input wire logic rst,
   input wire logic chan_en,
   input wire logic chan_reset_req,
   input wire logic listen_only,
   input wire logic [cbt_pkg::BRP_W-1:0] cfg_brp,
   input wire logic [cbt_pkg::SEG_W-1:0] cfg_prop,
   input wire logic [cbt_pkg::SEG_W-1:0] cfg_ph1,
   input wire logic [cbt_pkg::SEG_W-1:0] cfg_ph2,
   input wire logic [cbt_pkg::SJW_W-1:0] cfg_sjw,
   input wire logic cfg_load,
   input wire logic err_up,
   input wire logic err_dn,
   input wire logic tx_dominant,
   input wire logic ack_req,
   input wire logic rx_pin,
   output logic can_tx,
   output logic rx_bit,
   output logic sample_pulse,
   output logic bit_start,
   output logic [4:0] chan_state,
   output logic [cbt_pkg::ERR_W-1:0] err_count,
   output logic cfg_rejected,
   output logic cfg_applied,
   output logic [cbt_pkg::BRP_W-1:0] act_brp,
   output logic [cbt_pkg::SEG_W-1:0] act_prop,
   output logic [cbt_pkg::SEG_W-1:0] act_ph1,
   output logic [cbt_pkg::SEG_W-1:0] act_ph2,
   output logic [cbt_pkg::SJW_W-1:0] act_sjw
);

   typedef struct packed {
      cbt_pkg::cbt_chan_e state;
      logic [cbt_pkg::ERR_W-1:0] err;
      logic [cbt_pkg::BRP_W-1:0] brp;
      logic [cbt_pkg::SEG_W-1:0] prop;
      logic [cbt_pkg::SEG_W-1:0] ph1;
      logic [cbt_pkg::SEG_W-1:0] ph2;
      logic [cbt_pkg::SJW_W-1:0] sjw;
      logic rejected;
      logic applied;
      logic rx_s1;
      logic rx_s2;
      logic rx_prev;
      logic rx_bit;
      logic tx;
   } cbt_chan_s;

   localparam cbt_chan_s CHAN_RST = '{state: cbt_pkg::CH_INACTIVE,
      err: cbt_pkg::ERR_ZERO, brp: cbt_pkg::BRP_RST,
      prop: cbt_pkg::PROP_RST, ph1: cbt_pkg::PH1_RST,
      ph2: cbt_pkg::PH2_RST, sjw: cbt_pkg::SJW_RST, rejected: 1'b0,
      applied: 1'b0, rx_s1: 1'b1, rx_s2: 1'b1, rx_prev: 1'b1,
      rx_bit: 1'b1, tx: 1'b1};

   cbt_chan_s r_reg;
   cbt_chan_s r_next;
   logic cand_ok;
   logic run;
   logic rx_edge;
   logic tq_sample;
   logic [cbt_pkg::ERR_W:0] err_sum;

   cbt_timing_if cand_if ();
   cbt_timing_if appl_if ();

   // candidate fields go to the checker unregistered
   assign cand_if.brp = cfg_brp;
   assign cand_if.prop = cfg_prop;
   assign cand_if.ph1 = cfg_ph1;
   assign cand_if.ph2 = cfg_ph2;
   assign cand_if.sjw = cfg_sjw;

   // only an accepted set ever reaches the bit timer
   assign appl_if.brp = r_reg.brp;
   assign appl_if.prop = r_reg.prop;
   assign appl_if.ph1 = r_reg.ph1;
   assign appl_if.ph2 = r_reg.ph2;
   assign appl_if.sjw = r_reg.sjw;

   cbt_timing_check u_check (
      .cfg(cand_if.snk),
      .cfg_ok(cand_ok)
   );

   // timer stops while the channel takes no part in bus traffic
   assign run = (r_reg.state != cbt_pkg::CH_INACTIVE)
      && (r_reg.state != cbt_pkg::CH_BUSOFF);
   // recessive to dominant transition, seen after the synchroniser;
   // resync keeps us aligned only if other nodes share our rate
   assign rx_edge = r_reg.rx_prev && !r_reg.rx_s2;

   cbt_bit_timer u_timer (
      .clk(clk),
      .rst(rst),
      .cfg(appl_if.snk),
      .run(run),
      .rx_edge(rx_edge),
      .sample_pulse(tq_sample),
      .bit_start(bit_start)
   );

   assign sample_pulse = tq_sample;
   assign can_tx = r_reg.tx;
   assign rx_bit = r_reg.rx_bit;
   assign chan_state = r_reg.state;
   assign err_count = r_reg.err;
   assign cfg_rejected = r_reg.rejected;
   assign cfg_applied = r_reg.applied;
   assign act_brp = r_reg.brp;
   assign act_prop = r_reg.prop;
   assign act_ph1 = r_reg.ph1;
   assign act_ph2 = r_reg.ph2;
   assign act_sjw = r_reg.sjw;

   // next state of the channel
   always_comb begin
      r_next = r_reg;
      r_next.applied = 1'b0;
      err_sum = '0;
      // receive path: two flops before anything looks at the pin
      r_next.rx_s1 = rx_pin;
      r_next.rx_s2 = r_reg.rx_s1;
      r_next.rx_prev = r_reg.rx_s2;
      if (tq_sample) begin
         r_next.rx_bit = r_reg.rx_s2;
      end

      // a rejected set leaves the running timing untouched
      if (cfg_load) begin
         if (cand_ok) begin
            r_next.brp = cfg_brp;
            r_next.prop = cfg_prop;
            r_next.ph1 = cfg_ph1;
            r_next.ph2 = cfg_ph2;
            r_next.sjw = cfg_sjw;
            r_next.rejected = 1'b0;
            r_next.applied = 1'b1;
         end else begin
            r_next.rejected = 1'b1;
         end
      end

      // error counter: steps up by eight, down by one, saturating;
      // frozen once off the bus so the cause stays visible
      if (run) begin
         err_sum = {1'b0, r_reg.err};
         if (err_up) begin
            err_sum = err_sum + {1'b0, cbt_pkg::ERR_UP_STEP};
         end
         if (err_dn && (err_sum != '0)) begin
            err_sum = err_sum - {1'b0, cbt_pkg::ERR_DN_STEP};
         end
         if (err_sum[cbt_pkg::ERR_W]) begin
            r_next.err = cbt_pkg::ERR_SAT;
         end else begin
            r_next.err = err_sum[cbt_pkg::ERR_W-1:0];
         end
      end

      // state follows the counter; bus-off holds until reset or disable
      if (!chan_en) begin
         r_next.state = cbt_pkg::CH_INACTIVE;
         r_next.err = cbt_pkg::ERR_ZERO;
      end else if (r_reg.state == cbt_pkg::CH_BUSOFF) begin
         r_next.state = cbt_pkg::CH_BUSOFF;
      end else if (r_next.err > cbt_pkg::ERR_OFF_ABOVE) begin
         r_next.state = cbt_pkg::CH_BUSOFF;
      end else if (r_next.err >= cbt_pkg::ERR_PASSIVE) begin
         r_next.state = cbt_pkg::CH_PASSIVE;
      end else if (r_next.err >= cbt_pkg::ERR_WARN) begin
         r_next.state = cbt_pkg::CH_WARNING;
      end else begin
         r_next.state = cbt_pkg::CH_ACTIVE;
      end

      // pin drive: dominant only when participating and not observing
      r_next.tx = 1'b1;
      // enable is looked at directly so the pin goes quiet on the same
      // edge as the state goes inactive, not one cycle after the state
      if (run && chan_en && !listen_only
         && (tx_dominant || ack_req)) begin
         r_next.tx = 1'b0;
      end

      // channel reset keeps the saved timing, like a controller restart
      if (chan_reset_req) begin
         r_next.state = cbt_pkg::CH_INACTIVE;
         r_next.err = cbt_pkg::ERR_ZERO;
         r_next.tx = 1'b1;
         r_next.rx_bit = 1'b1;
         r_next.rejected = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         r_reg <= CHAN_RST;
      end else begin
         r_reg <= r_next;
      end
   end

endmodule

// >>> cbt_channel_checker.sv
/*
 cbt_channel_checker: concurrent checks on the ports of cbt_channel.
 assumes: bound to cbt_channel; one clock, sync active high rst.
*/
`timescale 1ns/10ps
module cbt_channel_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic chan_en,
   input wire logic chan_reset_req,
   input wire logic listen_only,
   input wire logic [cbt_pkg::BRP_W-1:0] cfg_brp,
   input wire logic [cbt_pkg::SEG_W-1:0] cfg_prop,
   input wire logic [cbt_pkg::SEG_W-1:0] cfg_ph1,
   input wire logic [cbt_pkg::SEG_W-1:0] cfg_ph2,
   input wire logic [cbt_pkg::SJW_W-1:0] cfg_sjw,
   input wire logic cfg_load,
   input wire logic tx_dominant,
   input wire logic can_tx,
   input wire logic [4:0] chan_state,
   input wire logic [cbt_pkg::ERR_W-1:0] err_count,
   input wire logic cfg_rejected,
   input wire logic cfg_applied,
   input wire logic [cbt_pkg::BRP_W-1:0] act_brp
);
   logic [17:0] prod;
   logic [4:0] tseg1;
   logic fld_ok;
   logic rate_bad;
   logic running;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // candidate checked independently of the design's own checker
   assign prod = 18'(cfg_brp) * (18'(cfg_prop) + 18'(cfg_ph1) +
                 18'(cfg_ph2) + 18'h00001);
   assign tseg1 = 5'(cfg_prop) + 5'(cfg_ph1);
   assign fld_ok = cfg_brp >= 9'h001 && cfg_brp <= 9'h100 &&
      cfg_prop inside {[4'h1:4'h8]} && cfg_ph1 inside {[4'h1:4'h8]} &&
      cfg_ph2 inside {[4'h2:4'h8]} && cfg_sjw inside {[3'h1:3'h4]};
   assign rate_bad = tseg1 < 5'h04 || prod < 18'h00019 || prod > 18'h01388;
   assign running = chan_en && !chan_reset_req && chan_state inside
      {cbt_pkg::CH_ACTIVE, cbt_pkg::CH_WARNING, cbt_pkg::CH_PASSIVE};
   a_active_range: assert property (
      chan_state == cbt_pkg::CH_ACTIVE |-> err_count < 9'h060)
      else $error("active with high count");
   a_warn_range: assert property (
      chan_state == cbt_pkg::CH_WARNING
      |-> err_count >= 9'h060 && err_count < 9'h080)
      else $error("warning out of range");
   a_passive_range: assert property (
      chan_state == cbt_pkg::CH_PASSIVE
      |-> err_count >= 9'h080 && err_count <= 9'h0ff)
      else $error("passive out of range");
   a_busoff_count: assert property (
      chan_state == cbt_pkg::CH_BUSOFF |-> err_count > 9'h0ff)
      else $error("bus-off with low count");
   a_busoff_quiet: assert property (
      chan_state == cbt_pkg::CH_BUSOFF
      && $past(chan_state) == cbt_pkg::CH_BUSOFF |-> can_tx)
      else $error("bus-off drives bus");
   a_listen_quiet: assert property (
      listen_only |=> can_tx)
      else $error("observe-only drives bus");
   a_tx_follows: assert property (
      running && tx_dominant && !listen_only |=> !can_tx)
      else $error("dominant not driven");
   a_disabled_idle: assert property (
      !chan_en |=> chan_state == cbt_pkg::CH_INACTIVE && can_tx)
      else $error("disabled channel active");
   a_field_refused: assert property (
      cfg_load && !fld_ok |=> cfg_rejected && !cfg_applied)
      else $error("bad field accepted");
   a_rate_refused: assert property (
      cfg_load && fld_ok && rate_bad |=> cfg_rejected && !cfg_applied)
      else $error("bad rate accepted");
   a_good_applied: assert property (
      cfg_load && fld_ok && !rate_bad
      |=> cfg_applied && !cfg_rejected && act_brp == $past(cfg_brp))
      else $error("good timing not applied");
   a_reset_clears: assert property (
      chan_reset_req |=> err_count == 9'h000 && !cfg_rejected)
      else $error("channel reset incomplete");
endmodule
bind cbt_channel cbt_channel_checker u_chk (.clk(clk), .rst(rst),
   .chan_en(chan_en), .chan_reset_req(chan_reset_req),
   .listen_only(listen_only), .cfg_brp(cfg_brp), .cfg_prop(cfg_prop),
   .cfg_ph1(cfg_ph1), .cfg_ph2(cfg_ph2), .cfg_sjw(cfg_sjw),
   .cfg_load(cfg_load), .tx_dominant(tx_dominant), .can_tx(can_tx),
   .chan_state(chan_state), .err_count(err_count),
   .cfg_rejected(cfg_rejected), .cfg_applied(cfg_applied),
   .act_brp(act_brp));

// >>> cbt_node_model.sv
/*
 cbt_node_model: another node on the shared bus, wired-and with ours.
 assumes: bus pulled recessive high; bench paces node_dom in whole bits.
*/
`timescale 1ns/10ps
module cbt_node_model (
   input wire logic can_tx,
   input wire logic node_dom,
   output logic rx_pin
);
   // dominant from either node wins; the pull-up gives recessive
   assign rx_pin = can_tx & ~node_dom;
endmodule

// >>> test_can_bit_timing_error_state.sv
/*
 test_can_bit_timing_error_state: self-checking bench for cbt_channel.
 assumes: cbt_pkg, cbt_node_model and the bound checker are compiled.
*/
`timescale 1ns/10ps
module test_can_bit_timing_error_state;
   logic clk = 0, rst = 1, chan_en = 0, chan_reset_req = 0, cfg_load = 0;
   logic listen_only = 0, err_up = 0, err_dn = 0, tx_dominant = 0;
   logic ack_req = 0, node_dom = 0, ld_d = 0, er_d = 0;
   logic [8:0] cfg_brp = 9'h005, err_count, act_brp, exp_cnt;
   logic [3:0] cfg_prop = 4'h3, cfg_ph1 = 4'h3, cfg_ph2 = 4'h3;
   logic [3:0] act_prop, act_ph1, act_ph2;
   logic [2:0] cfg_sjw = 3'h1, act_sjw;
   logic [4:0] chan_state;
   logic can_tx, rx_pin, rx_bit, sample_pulse, bit_start;
   logic cfg_rejected, cfg_applied;
   logic [1:0] q_cfg[$];
   logic [13:0] q_st[$];
   int n_mismatch = 0, checked = 0, seed = 32'h1fb7, i, n;
   always #20 clk = ~clk;
   cbt_channel u_dut (.clk(clk), .rst(rst), .chan_en(chan_en),
      .chan_reset_req(chan_reset_req), .listen_only(listen_only),
      .cfg_brp(cfg_brp), .cfg_prop(cfg_prop), .cfg_ph1(cfg_ph1),
      .cfg_ph2(cfg_ph2), .cfg_sjw(cfg_sjw), .cfg_load(cfg_load),
      .err_up(err_up), .err_dn(err_dn), .tx_dominant(tx_dominant),
      .ack_req(ack_req), .rx_pin(rx_pin), .can_tx(can_tx),
      .rx_bit(rx_bit), .sample_pulse(sample_pulse), .bit_start(bit_start),
      .chan_state(chan_state), .err_count(err_count),
      .cfg_rejected(cfg_rejected), .cfg_applied(cfg_applied),
      .act_brp(act_brp), .act_prop(act_prop), .act_ph1(act_ph1),
      .act_ph2(act_ph2), .act_sjw(act_sjw));
   cbt_node_model u_node (.can_tx(can_tx), .node_dom(node_dom),
      .rx_pin(rx_pin));
   task check(input logic [31:0] seen, input logic [31:0] exp,
              input string what);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task complete_run;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic logic [4:0] st(input logic [8:0] c);
      return c > 255 ? cbt_pkg::CH_BUSOFF : c >= 128 ? cbt_pkg::CH_PASSIVE :
         c >= 96 ? cbt_pkg::CH_WARNING : cbt_pkg::CH_ACTIVE;
   endfunction
   // one load per negedge; the caller lowers cfg_load after a burst
   task ld(input logic [8:0] b, input logic [3:0] p, input logic [3:0] a,
           input logic [3:0] c, input logic [2:0] j);
      logic g;
      int q;
      q = int'(b) * (1 + int'(p) + int'(a) + int'(c));
      g = b >= 1 && b <= 256 && p >= 1 && p <= 8 && a >= 1 && a <= 8 &&
         c >= 2 && c <= 8 && j >= 1 && j <= 4 && int'(p) + int'(a) >= 4 &&
         q >= 25 && q <= 5000;
      @(negedge clk);
      {cfg_brp, cfg_prop, cfg_ph1, cfg_ph2, cfg_sjw} = {b, p, a, c, j};
      cfg_load = 1;
      q_cfg.push_back(g ? 2'b10 : 2'b01);
   endtask
   // counter model: +8 per error, -1 per success, frozen once bus-off
   task ers(input int k, input logic u, input logic d);
      repeat (k) begin
         @(negedge clk);
         {err_up, err_dn} = {u, d};
         if (exp_cnt <= 255)
            exp_cnt = exp_cnt + (u ? 9'h008 : 9'h000) -
               ((d && (u || exp_cnt > 0)) ? 9'h001 : 9'h000);
         q_st.push_back({st(exp_cnt), exp_cnt});
      end
   endtask
   // bounded wait for the next bit_start (1) or sample_pulse (0)
   task cnt_to(input logic w, output int c);
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while ((w ? bit_start : sample_pulse) !== 1'b1 && c < 6000);
   endtask
   // answers come one cycle after the request that caused them
   always @(posedge clk) begin
      ld_d <= cfg_load;
      er_d <= err_up | err_dn;
   end
   always @(negedge clk) begin
      if (ld_d && q_cfg.size() > 0)
         check({cfg_applied, cfg_rejected}, q_cfg.pop_front(),
               "cfg");
      if (er_d && q_st.size() > 0)
         check({chan_state, err_count}, q_st.pop_front(),
               "errstate");
   end
   // hang guard, far above the expected run length
   initial begin
      #(40 * 20000);
      n_mismatch++;
      complete_run;
   end
   initial begin
      repeat (8) @(negedge clk);
      rst = 0;
      check({chan_state, err_count}, {cbt_pkg::CH_INACTIVE, 9'h000}, "rst");
      ld(9'h001, 4'h8, 4'h8, 4'h8, 3'h1);
      ld(9'h000, 4'h3, 4'h3, 4'h3, 3'h1);
      ld(9'h100, 4'h1, 4'h3, 4'h2, 3'h4);
      ld(9'h101, 4'h1, 4'h3, 4'h2, 3'h1);
      ld(9'h005, 4'h0, 4'h4, 4'h3, 3'h1);
      ld(9'h005, 4'h9, 4'h3, 4'h3, 3'h1);
      ld(9'h005, 4'h3, 4'h9, 4'h1, 3'h1);
      ld(9'h005, 4'h3, 4'h3, 4'h9, 3'h0);
      ld(9'h005, 4'h3, 4'h3, 4'h3, 3'h5);
      ld(9'h005, 4'h1, 4'h2, 4'h3, 3'h1);
      ld(9'h0fa, 4'h8, 4'h8, 4'h3, 3'h1);
      ld(9'h0fa, 4'h8, 4'h8, 4'h4, 3'h1);
      for (i = 0; i < 40; i++)
         ld(9'($unsigned($random(seed)) % 300),
            4'($unsigned($random(seed)) % 10),
            4'($unsigned($random(seed)) % 10),
            4'($unsigned($random(seed)) % 10),
            3'($unsigned($random(seed)) % 6));
      ld(9'h004, 4'h1, 4'h3, 4'h2, 3'h4);
      @(negedge clk) cfg_load = 0;
      check({act_brp, act_prop, act_ph1, act_ph2, act_sjw},
            {9'h004, 4'h1, 4'h3, 4'h2, 3'h4}, "applied");
      // the bit timer only runs while the channel is enabled
      chan_en = 1;
      repeat (2) @(negedge clk);
      check(chan_state, cbt_pkg::CH_ACTIVE, "enable");
      // bit of 4 * (1 + 4 + 2) clocks, sample point after 4 * 5
      cnt_to(1, n);
      cnt_to(0, n);
      check(n, 20, "tseg1 span");
      cnt_to(1, n);
      check(n, 8, "tseg2 span");
      exp_cnt = 0;
      ers(3, 0, 1);
      ers(16, 1, 0);
      ers(1, 0, 1);
      ers(1, 1, 1);
      ers(16, 1, 0);
      ers(2, 1, 1);
      @(negedge clk) {err_up, err_dn, tx_dominant} = 3'b001;
      repeat (2) @(negedge clk);
      check(can_tx, 1, "bus-off tx");
      chan_reset_req = 1;
      @(negedge clk) chan_reset_req = 0;
      check(err_count, 0, "chan reset");
      repeat (2) @(negedge clk);
      check({chan_state, can_tx}, {cbt_pkg::CH_ACTIVE, 1'b0}, "tx");
      // acknowledge alone must also pull the pin dominant
      {tx_dominant, ack_req} = 2'b01;
      repeat (2) @(negedge clk);
      check(can_tx, 0, "ack drive");
      {tx_dominant, listen_only, ack_req} = 3'b111;
      repeat (2) @(negedge clk);
      check(can_tx, 1, "observe tx");
      {tx_dominant, ack_req, node_dom} = 3'b001;
      cnt_to(0, n);
      cnt_to(0, n);
      @(negedge clk);
      check(rx_bit, 0, "rx dominant");
      node_dom = 0;
      cnt_to(0, n);
      cnt_to(0, n);
      @(negedge clk);
      check(rx_bit, 1, "rx recessive");
      chan_en = 0;
      repeat (2) @(negedge clk);
      check({chan_state, err_count}, {cbt_pkg::CH_INACTIVE, 9'h000}, "off");
      complete_run;
   end
endmodule
